// file: core/tdm_dev_end.sv
/*
  Channel-access end of a four-channel controller: processor port,
  register file, bit counter, slot selection and serial drivers.
  Assumes all link pins are asynchronous to aclk; bus-style straps
  are static levels from logic on aclk.
*/
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module tdm_dev_end
  import tdm_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  tdm_if.dev              link,
  input  wire logic       mux_mode,
  input  wire logic       ds_style,
  input  wire logic       wide_bus,
  output logic [1:0]      mode_now
);
  logic [25:0] sync1_reg, sync2_reg;
  logic [3:0]  prev_reg;
  logic [7:0]  ad_s;
  logic [6:0]  addr_s;
  logic        cs_n_s, wr_s, rd_s, ale_s, rst_s, dcl_s, fsc_s;
  logic [3:0]  rx_s;
  logic        rst;
  logic [7:0]  cfg_reg;
  logic [1:0]  len_sel_reg [NUM_CH];
  logic [7:0]  pos_reg [NUM_CH];
  logic [7:0]  tx_reg [NUM_CH];
  logic [7:0]  rx_reg [NUM_CH];
  logic [7:0]  shift_reg [NUM_CH];
  logic [3:0]  pend_reg, act_reg;
  logic [7:0]  alat_reg;
  logic [8:0]  cnt_reg, cnt_next;
  logic        phase_reg, fs_pend_reg;
  logic [7:0]  host_addr, rd_val;
  logic [6:0]  idx;
  logic        wr_evt, rd_on, rd_end, dcl_rise, dcl_fall, launch, sample;
  logic        dbl, od;
  conn_mode_e  mode;
  logic [3:0]  act;
  logic [2:0]  bidx [NUM_CH];
  logic [3:0]  line_act, line_bit;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
      prev_reg  <= 4'hC;
    end else begin
      sync1_reg <= {link.addr_data, link.reg_addr, link.cs_n, link.wr_n_or_dir,
                    link.rd_n_or_data_strobe, link.ale, link.reset_in,
                    link.bit_clock_in, link.frame_sync_in, link.serial_rx};
      sync2_reg <= sync1_reg;
      prev_reg  <= {wr_s, rd_s, dcl_s, fsc_s};
    end
  end
  assign {ad_s, addr_s, cs_n_s, wr_s, rd_s, ale_s, rst_s, dcl_s, fsc_s, rx_s} = sync2_reg;
  assign rst = !aresetn || rst_s;

  // ==========================================================
  // Processor port decode
  assign mode = conn_mode_e'(cfg_reg[CFG_MODE_LO +: 2]);
  assign dbl  = cfg_reg[CFG_CLK_DOUBLE];
  assign od   = cfg_reg[CFG_OPEN_DRAIN] || (mode == MODE_SINGLE_FRAME);
  assign host_addr = mux_mode ? alat_reg : {1'b0, addr_s};
  assign idx = wide_bus ? host_addr[7:1] : host_addr[6:0];
  // Direction pin is wr_s and strobe is rd_s in the strobe style
  assign wr_evt = !cs_n_s && (ds_style ? (rd_s && !prev_reg[2] && !wr_s)
                                       : (wr_s && !prev_reg[3]));
  // Demuxed strobe style ties the latch strobe high, so it gates muxed reads only
  assign rd_on  = !cs_n_s && !(mux_mode && ale_s) && !rd_s
                  && (!ds_style || wr_s);
  assign rd_end = !cs_n_s && rd_s && !prev_reg[2] && (!ds_style || wr_s);

  always_ff @(posedge aclk) begin
    if (rst) begin
      alat_reg <= 8'h00;
    end else if (ale_s && !cs_n_s) begin
      alat_reg <= ad_s;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    if (idx == ADDR_CONFIG) begin
      rd_val = cfg_reg;
    end else if (idx == ADDR_PENDING) begin
      rd_val = {4'h0, pend_reg};
    end
    for (int k = 0; k < NUM_CH; k++) begin
      if (idx == ADDR_LEN_BASE + 7'(k)) rd_val = {6'h00, len_sel_reg[k]};
      if (idx == ADDR_POS_BASE + 7'(k)) rd_val = pos_reg[k];
      if (idx == ADDR_TX_BASE + 7'(k))  rd_val = tx_reg[k];
      if (idx == ADDR_RX_BASE + 7'(k))  rd_val = rx_reg[k];
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      cfg_reg <= 8'h00;
      for (int k = 0; k < NUM_CH; k++) begin
        len_sel_reg[k] <= 2'h0;
        pos_reg[k]     <= 8'h00;
        tx_reg[k]      <= 8'hFF;
      end
    end else if (wr_evt) begin
      if (idx == ADDR_CONFIG) cfg_reg <= ad_s;
      for (int k = 0; k < NUM_CH; k++) begin
        if (idx == ADDR_LEN_BASE + 7'(k)) len_sel_reg[k] <= ad_s[1:0];
        if (idx == ADDR_POS_BASE + 7'(k)) pos_reg[k] <= ad_s;
        if (idx == ADDR_TX_BASE + 7'(k))  tx_reg[k] <= ad_s;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      link.dev_ad_out <= 8'h00;
      link.dev_ad_oe  <= 1'b0;
      link.irq_o      <= 1'b0;
      link.irq_oe     <= 1'b0;
      mode_now        <= 2'h0;
    end else begin
      link.dev_ad_out <= rd_val;
      link.dev_ad_oe  <= rd_on;
      link.irq_o      <= 1'b0;
      link.irq_oe     <= |pend_reg;
      mode_now        <= cfg_reg[CFG_MODE_LO +: 2];
    end
  end

  // ==========================================================
  // Bit timing
  assign dcl_rise = dcl_s && !prev_reg[1];
  assign dcl_fall = !dcl_s && prev_reg[1];
  // A pending sync edge forces a launch so the new frame starts on phase
  assign launch = dcl_rise && (!dbl || !phase_reg || fs_pend_reg);
  assign sample = dcl_fall && (!dbl || !phase_reg);

  always_comb begin
    if (fs_pend_reg) begin
      cnt_next = 9'h000;
    end else if (!cfg_reg[CFG_FRAME_512] && cnt_reg == FRAME_256_LAST) begin
      cnt_next = 9'h000;
    end else begin
      cnt_next = cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      cnt_reg     <= 9'h000;
      phase_reg   <= 1'b0;
      fs_pend_reg <= 1'b0;
    end else begin
      fs_pend_reg <= (fsc_s && !prev_reg[0]) || (fs_pend_reg && !launch);
      if (dcl_rise) phase_reg <= launch && dbl;
      if (launch) cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // Slot selection per channel
  always_comb begin
    logic [8:0] start;
    logic [8:0] off;
    logic [3:0] len;
    start = 9'h000;
    off   = 9'h000;
    len   = 4'h0;
    for (int k = 0; k < NUM_CH; k++) begin
      if (mode == MODE_SINGLE_FRAME) begin
        // D bits lead the control byte, the fourth byte of a channel
        start = 9'(D_BIT_OFFSET + SUB_CH_BITS * k
                   + (cfg_reg[CFG_GROUP_SEL] ? GROUP_OFFSET : 0));
        len   = D_LEN;
      end else begin
        start = {pos_reg[k], 1'b0};
        len   = SLOT_LEN[len_sel_reg[k]];
      end
      off = cnt_next - start;
      if (mode == MODE_QUAD_STROBE) begin
        act[k]  = fsc_s;
        bidx[k] = cnt_next[2:0];
      end else begin
        act[k]  = off < {5'h00, len};
        bidx[k] = off[2:0];
      end
    end
  end

  always_comb begin
    line_act = 4'h0;
    line_bit = 4'hF;
    if (mode == MODE_QUAD_STROBE || mode == MODE_QUAD_SLOT) begin
      for (int k = 0; k < NUM_CH; k++) begin
        line_act[k] = act[k];
        line_bit[k] = tx_reg[k][3'h7 - bidx[k]];
      end
    end else begin
      // Overlapping slots on the shared line: lowest channel wins
      for (int k = NUM_CH - 1; k >= 0; k--) begin
        if (act[k]) begin
          line_act[0] = 1'b1;
          line_bit[0] = tx_reg[k][3'h7 - bidx[k]];
        end
      end
    end
  end

  // ==========================================================
  // Serial drivers and receivers
  always_ff @(posedge aclk) begin
    if (rst) begin
      link.serial_tx_out   <= 4'hF;
      link.serial_tx_oe    <= 4'h0;
      link.tristate_ctrl_n <= 1'b1;
      act_reg              <= 4'h0;
    end else begin
      if (launch) begin
        for (int l = 0; l < NUM_CH; l++) begin
          link.serial_tx_out[l] <= od ? 1'b0 : line_bit[l];
          link.serial_tx_oe[l]  <= line_act[l] && (!od || !line_bit[l]);
        end
        act_reg <= act;
      end
      unique case (mode)
        MODE_QUAD_STROBE: link.tristate_ctrl_n <= !fsc_s;
        MODE_QUAD_SLOT:   if (launch) link.tristate_ctrl_n <= !act[1];
        MODE_SINGLE_SLOT, MODE_SINGLE_FRAME: begin
          if (launch) link.tristate_ctrl_n <= !(|act);
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      pend_reg <= 4'h0;
      for (int k = 0; k < NUM_CH; k++) begin
        shift_reg[k] <= 8'h00;
        rx_reg[k]    <= 8'h00;
      end
    end else begin
      for (int k = 0; k < NUM_CH; k++) begin
        if (sample && act_reg[k]) begin
          shift_reg[k] <= {shift_reg[k][6:0], mode[0] ? rx_s[k] : rx_s[0]};
        end
        if (launch && act_reg[k] && !act[k]) begin
          rx_reg[k] <= shift_reg[k];
        end
      end
      // A slot ending in the read's last cycle stays pending
      pend_reg <= (pend_reg & ~{4{rd_end && idx == ADDR_PENDING}})
                | ({4{launch}} & act_reg & ~act);
    end
  end
endmodule

// file: core/tdm_pkg.sv
/*
  Constants shared by both ends of the TDM channel-access link.
  Assumes a 10 MHz aclk on both ends.
*/
package tdm_pkg;
  // ==========================================================
  // Modes and sizes
  typedef enum logic [1:0] {
    MODE_SINGLE_SLOT  = 2'b00,
    MODE_QUAD_STROBE  = 2'b01,
    MODE_SINGLE_FRAME = 2'b10,
    MODE_QUAD_SLOT    = 2'b11
  } conn_mode_e;
  localparam int NUM_CH = 4;
  // ==========================================================
  // Device register indices (7-bit register address space)
  localparam logic [6:0] ADDR_CONFIG   = 7'h00;
  localparam logic [6:0] ADDR_LEN_BASE = 7'h04;
  localparam logic [6:0] ADDR_POS_BASE = 7'h08;
  localparam logic [6:0] ADDR_TX_BASE  = 7'h0C;
  localparam logic [6:0] ADDR_RX_BASE  = 7'h10;
  localparam logic [6:0] ADDR_PENDING  = 7'h14;
  // common_config_reg fields
  localparam int CFG_MODE_LO    = 0;
  localparam int CFG_GROUP_SEL  = 2;
  localparam int CFG_CLK_DOUBLE = 3;
  localparam int CFG_OPEN_DRAIN = 4;
  localparam int CFG_FRAME_512  = 5;
  // ==========================================================
  // Frame geometry
  localparam int SUB_CH_BITS  = 32;
  localparam int D_BIT_OFFSET = 24;
  localparam int GROUP_OFFSET = 128;
  localparam logic [8:0] FRAME_256_LAST = 9'h0FF;
  localparam logic [3:0] D_LEN = 4'h2;
  localparam logic [3:0] SLOT_LEN [4] = '{4'h1, 4'h2, 4'h7, 4'h8};
  // Idle levels of the synchronised processor pins: cs_n, wr, rd high
  localparam logic [25:0] SYNC_IDLE = 26'h000_0700;
  localparam logic [7:0]  AD_PULLUP = 8'hFF;
  // ==========================================================
  // Host controller: AXI4-Lite map and pin timing
  localparam logic [7:0] AXI_CMD    = 8'h00;
  localparam logic [7:0] AXI_STATUS = 8'h04;
  localparam logic [7:0] AXI_CTRL   = 8'h08;
  localparam int CMD_READ    = 8;
  localparam int CMD_WDATA   = 16;
  localparam int STAT_IRQ    = 1;
  localparam int STAT_RDATA  = 8;
  localparam int CTRL_MUX    = 0;
  localparam int CTRL_DS     = 1;
  localparam int CTRL_RESET  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_NS  = 100;
  localparam int STEP_NS = 800;
  localparam logic [3:0] STEP_CYC = 4'(STEP_NS / CLK_NS);
endpackage

// file: core/tdm_if.sv
/*
  Pins between the processor-side host and the channel-access device.
  Assumes the bench drives the serial highway side: bit clock, frame
  sync and receive lines, and watches the resolved transmit lines.
*/
`timescale 1ns/1ps
interface tdm_if;
  import tdm_pkg::*;
  logic [7:0] host_ad_out;
  logic       host_ad_oe;
  logic [7:0] dev_ad_out;
  logic       dev_ad_oe;
  logic [7:0] addr_data;
  logic [6:0] reg_addr;
  logic       cs_n;
  logic       wr_n_or_dir;
  logic       rd_n_or_data_strobe;
  logic       ale;
  logic       reset_in;
  logic       irq_o;
  logic       irq_oe;
  logic       irq_n;
  logic       bit_clock_in;
  logic       frame_sync_in;
  logic [3:0] serial_rx;
  logic [3:0] serial_tx_out;
  logic [3:0] serial_tx_oe;
  logic [3:0] serial_tx;
  logic       tristate_ctrl_n;

  // ==========================================================
  // Wire resolution; undriven lines float high via pull-ups
  assign addr_data = host_ad_oe ? host_ad_out : (dev_ad_oe ? dev_ad_out : AD_PULLUP);
  assign irq_n     = irq_oe ? irq_o : 1'b1;
  for (genvar i = 0; i < NUM_CH; i++) begin : g_tx
    assign serial_tx[i] = serial_tx_oe[i] ? serial_tx_out[i] : 1'b1;
  end

  modport dev (
    input  addr_data, reg_addr, cs_n, wr_n_or_dir, rd_n_or_data_strobe, ale,
    input  reset_in, bit_clock_in, frame_sync_in, serial_rx,
    output dev_ad_out, dev_ad_oe, irq_o, irq_oe, serial_tx_out, serial_tx_oe,
    output tristate_ctrl_n
  );
  modport host (
    input  addr_data, irq_n,
    output host_ad_out, host_ad_oe, reg_addr, cs_n, wr_n_or_dir,
    output rd_n_or_data_strobe, ale, reset_in
  );
endinterface

// file: core/tdm_host_end.sv
/*
  Processor-side end: takes commands over AXI4-Lite and runs one
  register access at a time on the device's processor port.
  Assumes the device answers reads within one pin step.
*/
`timescale 1ns/1ps
module tdm_host_end
  import tdm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  tdm_if.host              link,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ALE    = 3'b001,
    ST_SETUP  = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100
  } state_e;
  state_e      state_reg;
  logic [3:0]  step_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [23:0] cmd_reg;
  logic [2:0]  ctrl_reg;
  logic [7:0]  rbyte_reg;
  logic [8:0]  sync1_reg, sync2_reg;
  logic        wr_fire, busy, is_rd, mux, ds;

  assign wr_fire = !awready && !wready && !bvalid;
  assign busy    = state_reg != ST_IDLE;
  assign is_rd   = cmd_reg[CMD_READ];
  assign mux     = ctrl_reg[CTRL_MUX];
  assign ds      = ctrl_reg[CTRL_DS];

  // ==========================================================
  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        awaddr_reg <= awaddr;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_reg <= wdata;
        wready    <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (awaddr_reg == AXI_CMD || awaddr_reg == AXI_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h0000_0000;
      unique case (araddr)
        AXI_CMD:    rdata[23:0] <= cmd_reg;
        AXI_STATUS: rdata[15:0] <= {rbyte_reg, 6'h00, !sync2_reg[0], busy};
        AXI_CTRL:   rdata[2:0]  <= ctrl_reg;
        default:    rresp       <= RESP_SLVERR;
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // Command registers; a command written while busy is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_reg  <= 24'h00_0000;
      ctrl_reg <= 3'h0;
    end else if (wr_fire && awaddr_reg == AXI_CTRL) begin
      ctrl_reg <= wdata_reg[2:0];
    end else if (wr_fire && awaddr_reg == AXI_CMD && !busy) begin
      cmd_reg <= wdata_reg[23:0];
    end
  end

  // ==========================================================
  // Pin sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 9'h1FF;
      sync2_reg <= 9'h1FF;
    end else begin
      sync1_reg <= {link.addr_data, link.irq_n};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      step_reg  <= 4'h0;
      rbyte_reg <= 8'h00;
    end else if (state_reg == ST_IDLE) begin
      step_reg <= 4'h0;
      if (wr_fire && awaddr_reg == AXI_CMD) begin
        state_reg <= mux ? ST_ALE : ST_SETUP;
      end
    end else if (step_reg != STEP_CYC - 4'h1) begin
      step_reg <= step_reg + 4'h1;
    end else begin
      step_reg <= 4'h0;
      unique case (state_reg)
        ST_ALE:    state_reg <= ST_SETUP;
        ST_SETUP:  state_reg <= ST_STROBE;
        ST_STROBE: begin
          state_reg <= ST_HOLD;
          if (is_rd) rbyte_reg <= sync2_reg[8:1];
        end
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.host_ad_out         <= 8'h00;
      link.host_ad_oe          <= 1'b0;
      link.reg_addr            <= 7'h00;
      link.cs_n                <= 1'b1;
      link.wr_n_or_dir         <= 1'b1;
      link.rd_n_or_data_strobe <= 1'b1;
      link.ale                 <= 1'b0;
      link.reset_in            <= 1'b0;
    end else begin
      link.reset_in            <= ctrl_reg[CTRL_RESET];
      link.reg_addr            <= cmd_reg[6:0];
      link.cs_n                <= !busy;
      link.ale                 <= mux ? state_reg == ST_ALE : ds;
      link.host_ad_out         <= state_reg == ST_ALE ? {1'b0, cmd_reg[6:0]}
                                                      : cmd_reg[CMD_WDATA +: 8];
      link.host_ad_oe          <= state_reg == ST_ALE || (busy && !is_rd);
      if (ds) begin
        link.wr_n_or_dir         <= !busy || is_rd;
        link.rd_n_or_data_strobe <= state_reg != ST_STROBE;
      end else begin
        link.wr_n_or_dir         <= !(state_reg == ST_STROBE && !is_rd);
        link.rd_n_or_data_strobe <= !(state_reg == ST_STROBE && is_rd);
      end
    end
  end
endmodule

// file: verification/tdm_link_monitor.sv
/*
  Checker for the pins between the host end and the device end.
  Assumes it is instantiated beside the interface, on the aclk domain.
*/
`timescale 1ns/1ps
module tdm_link_monitor
  import tdm_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cs_n,
  input wire logic       ale,
  input wire logic       host_ad_oe,
  input wire logic       dev_ad_oe,
  input wire logic       reset_in,
  input wire logic       irq_o,
  input wire logic       irq_oe,
  input wire logic       frame_sync_in,
  input wire logic [3:0] serial_tx_out,
  input wire logic [3:0] serial_tx_oe,
  input wire logic       tristate_ctrl_n,
  input wire logic       mux_mode,
  input wire logic [1:0] mode_now
);
  // ==========================================================
  // Settle counter: a slot begun in the old mode may run on for a while
  logic [7:0] quiet_reg;
  wire        settled = quiet_reg == 8'hFF;
  always_ff @(posedge aclk) begin
    if (!aresetn || !$stable(mode_now)) quiet_reg <= 8'h00;
    else if (!settled) quiet_reg <= quiet_reg + 8'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Named steps
  sequence s_strobe_on;
    (settled && mode_now == MODE_QUAD_STROBE && frame_sync_in) [*5];
  endsequence
  // Drivers let go only at the next launch, up to eight cycles after the strobe
  sequence s_strobe_off;
    (settled && mode_now == MODE_QUAD_STROBE && !frame_sync_in) [*8];
  endsequence
  sequence s_reset_held;
    reset_in [*6];
  endsequence
  // ==========================================================
  // Properties
  AST_RD_CS: assert property (dev_ad_oe |-> !cs_n)
    else $error("device drives data while not selected");
  AST_RD_ALE: assert property (mux_mode && dev_ad_oe |-> !ale)
    else $error("device drives data during address phase");
  AST_BUS_ONE: assert property (dev_ad_oe |-> !host_ad_oe)
    else $error("both ends drive the data lines");
  AST_RESET: assert property (s_reset_held |->
    serial_tx_oe == 4'h0 && tristate_ctrl_n && !irq_oe && !dev_ad_oe)
    else $error("device outputs active while reset input high");
  AST_IRQ_OD: assert property (irq_oe |-> !irq_o)
    else $error("interrupt line driven high");
  AST_TSC_ON: assert property (s_strobe_on |-> !tristate_ctrl_n)
    else $error("tristate control idle during strobe");
  AST_TSC_OFF: assert property (s_strobe_off |->
    tristate_ctrl_n && serial_tx_oe == 4'h0)
    else $error("tristate control or output active outside strobe");
  AST_LINE_ZERO: assert property (settled && !mode_now[0] |->
    serial_tx_oe[3:1] == 3'b000)
    else $error("single line mode drives lines 1 to 3");
  AST_FRAME_OD: assert property (settled && mode_now == MODE_SINGLE_FRAME |->
    (serial_tx_oe & serial_tx_out) == 4'h0)
    else $error("structured mode drives a one");
endmodule

// file: verification/tdm_channel_access_hdlc_quad_test.sv
/*
  Self-checking bench: host end and device end joined by one interface.
  Assumes the package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
module tdm_channel_access_hdlc_quad_test;
  import tdm_pkg::*;
  logic        aclk, aresetn, bclk, fsync, mux, ds, wide;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, lf, mdl [128];
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, mode_now;
  logic [2:0]  rxr;
  int          error_cnt, tests_run;
  tdm_if ifc ();
  assign ifc.bit_clock_in = bclk;
  assign ifc.frame_sync_in = fsync;
  // Line 0 loops back so a channel hears its own slot
  assign ifc.serial_rx = {rxr, ifc.serial_tx[0]};
  tdm_host_end tdm_host_end_i (.aclk, .aresetn, .link(ifc), .awaddr, .awvalid, .awready,
    .wdata, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  tdm_dev_end tdm_dev_end_i (.aclk, .aresetn, .link(ifc), .mux_mode(mux), .ds_style(ds),
    .wide_bus(wide), .mode_now);
  tdm_link_monitor tdm_link_monitor_i (.aclk, .aresetn, .cs_n(ifc.cs_n), .ale(ifc.ale),
    .host_ad_oe(ifc.host_ad_oe), .dev_ad_oe(ifc.dev_ad_oe), .reset_in(ifc.reset_in),
    .irq_o(ifc.irq_o), .irq_oe(ifc.irq_oe), .frame_sync_in(ifc.frame_sync_in),
    .serial_tx_out(ifc.serial_tx_out), .serial_tx_oe(ifc.serial_tx_oe),
    .tristate_ctrl_n(ifc.tristate_ctrl_n), .mux_mode(mux), .mode_now);
  // ==========================================================
  // Clocks and helpers
  always #50 aclk = ~aclk;
  always #400 bclk = ~bclk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  always @(posedge bclk) begin
    lf = lfsr(lf);
    rxr <= lf[2:0];
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // One register access on the processor port; wide buses use even addresses
  task automatic dev_acc(input logic [6:0] idx, input logic rd, input logic [7:0] wd,
                         output logic [7:0] rb);
    logic [31:0] c;
    logic [31:0] s;
    logic [1:0]  r;
    c = 32'h0000_0000;
    c[6:0] = wide ? {idx[5:0], 1'b0} : idx;
    c[CMD_READ] = rd;
    c[CMD_WDATA +: 8] = wd;
    axi_wr(AXI_CMD, c, r);
    s = 32'h0000_0001;
    while (s[0]) axi_rd(AXI_STATUS, s, r);
    rb = s[STAT_RDATA +: 8];
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0]  v;
    logic [7:0]  cfg;
    logic [31:0] s;
    logic [1:0]  r;
    {aclk, aresetn, bclk, fsync, mux, ds, wide, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata, rxr} = '0;
    lf = 8'h4E;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_wr(8'h10, 32'h0000_0000, r);
    chk({6'h00, r}, {6'h00, RESP_SLVERR}, "aw unmapped");
    axi_rd(8'h10, s, r);
    chk({6'h00, r}, {6'h00, RESP_SLVERR}, "ar unmapped");
    for (int m = 0; m < 4; m++) begin
      // Straps follow the host style while the device is held in reset
      axi_wr(AXI_CTRL, 32'(m) | 32'h0000_0004, r);
      mux <= m[0];
      ds <= m[1];
      wide <= m[0] & m[1];
      repeat (8) @(posedge aclk);
      axi_wr(AXI_CTRL, 32'(m), r);
      for (int i = 0; i < 128; i++) mdl[i] = (i >= 12 && i < 16) ? 8'hFF : 8'h00;
      dev_acc(ADDR_TX_BASE + 7'h02, 1'b1, 8'h00, v);
      chk(v, mdl[14], "tx reset value");
      lf = lfsr(lf);
      mdl[9] = lf;
      dev_acc(ADDR_POS_BASE + 7'h01, 1'b0, lf, v);
      dev_acc(ADDR_POS_BASE + 7'h01, 1'b1, 8'h00, v);
      chk(v, mdl[9], "slot position");
      if (m == 0) begin
        lf = lfsr(lf);
        mdl[12] = lf;
        dev_acc(ADDR_TX_BASE, 1'b0, lf, v);
        dev_acc(ADDR_LEN_BASE, 1'b0, 8'h03, v);
        dev_acc(ADDR_POS_BASE, 1'b0, 8'h04, v);
      end
      if (m == 2) begin
        for (int k = 0; k < 4; k++) begin
          dev_acc(ADDR_LEN_BASE + 7'(k), 1'b0, 8'h00, v);
          dev_acc(ADDR_POS_BASE + 7'(k), 1'b0, 8'h0C + 8'(k * 16), v);
        end
        dev_acc(ADDR_POS_BASE + 7'h03, 1'b1, 8'h00, v);
        chk(v, 8'h3C, "structured slot");
      end
      // Last mode also turns on double-rate clock, open drain and long frames
      cfg = (m == 2) ? 8'h06 : (m == 3) ? 8'h3B : 8'(m);
      dev_acc(ADDR_CONFIG, 1'b0, cfg, v);
      dev_acc(ADDR_CONFIG, 1'b1, 8'h00, v);
      chk(v, cfg, "config");
      chk({6'h00, mode_now}, 8'(m), "mode");
      repeat (40) @(negedge bclk);
      fsync <= 1'b1;
      repeat ((m == 1) ? 10 : 1) @(negedge bclk);
      if (m == 1) chk({7'h00, ifc.tristate_ctrl_n}, 8'h00, "strobe tsc");
      fsync <= 1'b0;
      repeat ((m == 2) ? 300 : 24) @(negedge bclk);
      if (m == 0) begin
        dev_acc(ADDR_RX_BASE, 1'b1, 8'h00, v);
        chk(v, mdl[12], "loopback byte");
        axi_rd(AXI_STATUS, s, r);
        chk({7'h00, s[STAT_IRQ]}, 8'h01, "irq pending");
        dev_acc(ADDR_PENDING, 1'b1, 8'h00, v);
        chk(v & 8'h0D, 8'h0D, "pending");
      end
      $display("mode %0d done, mismatches %0d", m, error_cnt);
    end
    give_verdict();
  end
  // Whole run is near 6000 cycles; the limit is several times that
  initial begin
    #2_000_000;
    error_cnt++;
    give_verdict();
  end
endmodule
